// ### design/fpm_flash_ctrl.sv
// fpm_flash_ctrl: flash array model, page buffer, op timer, crc, boot select
// assumes one 10 MHz clock, async high reset, classic wishbone single cycle
`default_nettype none
module fpm_flash_ctrl
	import fpm_pkg::*;
#(
	parameter int OP_CYC = OP_CYCLES
) (
	// clock, reset, enable
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        ce,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// boot control
	input  wire logic        force_isp,
	output logic      [15:0] reset_start_addr,
	output logic      [7:0]  user_config_byte,
	output logic             busy
);
	typedef enum {S_IDLE, S_WAIT, S_CRC} fpm_st_t;
	fpm_st_t     st_q;
	logic [7:0]  mem [MEM_BYTES];
	logic [7:0]  pbuf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] pload_q;
	// flash cells: factory values, kept through rst
	logic [7:0]  sec_q [SECTORS] = '{default: SEC_RST};
	logic [12:0] addr_q;
	logic [7:0]  data_q;
	logic [7:0]  rdata_q;
	logic [31:0] crc_q;
	logic [12:0] cidx_q;
	logic [12:0] cend_q;
	logic [31:0] tmr_q;
	fpm_cmd_t    op_q;
	logic        err_q;
	logic        prot_q;
	logic        bstat_q   = 1'b1;
	logic [7:0]  bvec_q    = BVEC_RST_8K;
	logic [7:0]  ucfg_nv_q = UCFG_RST;
	logic        latched_q;
	logic        ack_q;
	logic [31:0] dat_q;

	wire         req     = wb_cyc_i & wb_stb_i & ~ack_q;
	wire         wr      = req & wb_we_i & wb_sel_i[0];
	wire [2:0]   sect    = addr_q[12:10];
	wire         locked  = sec_q[sect][0];
	wire [3:0]   cmd_raw = wb_dat_i[3:0];
	wire         cmd_go  = wr & (wb_adr_i == R_CMD) & (st_q == S_IDLE);
	wire [31:0]  tmr_end = OP_CYC - 1;

	function automatic logic [31:0] crc_step(input logic [31:0] c,
		input logic [7:0] b);
		logic [31:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[31] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		unique case (a)
			R_ADDR:  rd_mux = {19'h0, addr_q};
			R_DATA:  rd_mux = {24'h0, rdata_q};
			R_STAT:  rd_mux = {29'h0, busy, err_q, prot_q};
			R_CRC:   rd_mux = crc_q;
			R_BOOT:  rd_mux = {23'h0, bstat_q, bvec_q};
			R_UCFG:  rd_mux = {16'h0, ucfg_nv_q, user_config_byte};
			R_SEC:   rd_mux = {24'h0, sec_q[sect]};
			R_START: rd_mux = {16'h0, reset_start_addr};
			default: rd_mux = 32'h0;
		endcase
	endfunction

	// bus answer: one wait state, ack on second edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ack_q    <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else if (ce) begin
			ack_q    <= req;
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_mux(wb_adr_i) : 32'h0;
		end
	end

	// address / data latches, written only while the sequencer is idle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			addr_q <= 13'h0;
			data_q <= 8'h0;
		end else if (ce && wr && st_q == S_IDLE) begin
			if (wb_adr_i == R_ADDR)
				addr_q <= wb_dat_i[12:0];
			if (wb_adr_i == R_DATA)
				data_q <= wb_dat_i[7:0];
		end
	end

	// sequencer; commands while busy are dropped
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q    <= S_IDLE;
			op_q    <= CMD_NONE;
			tmr_q   <= 32'h0;
			busy    <= 1'b0;
			err_q   <= 1'b0;
			prot_q  <= 1'b0;
			crc_q   <= 32'h0;
			cidx_q  <= 13'h0;
			cend_q  <= 13'h0;
			rdata_q <= 8'h0;
			pload_q <= '0;
		end else if (ce) begin
			unique case (st_q)
				S_IDLE: if (cmd_go) begin
					err_q  <= 1'b0;
					prot_q <= 1'b0;
					op_q   <= fpm_cmd_t'(cmd_raw);
					tmr_q  <= 32'h0;
					unique case (fpm_cmd_t'(cmd_raw))
						CMD_RD_BYTE: rdata_q <= mem[addr_q];
						CMD_LOAD_BUF: pload_q[addr_q[5:0]] <= 1'b1;
						CMD_CRC_SECT: begin
							st_q   <= S_CRC;
							busy   <= 1'b1;
							crc_q  <= CRC_INIT;
							cidx_q <= {sect, 10'h0};
							cend_q <= {sect, 10'h3ff};
						end
						CMD_CRC_ALL: begin
							st_q   <= S_CRC;
							busy   <= 1'b1;
							crc_q  <= CRC_INIT;
							cidx_q <= 13'h0;
							cend_q <= 13'h1fff;
						end
						CMD_ER_BYTE, CMD_ER_PAGE, CMD_ER_SECT,
						CMD_PROG_PAGE: begin
							if (locked) begin
								prot_q <= 1'b1;
								err_q  <= 1'b1;
							end else begin
								st_q <= S_WAIT;
								busy <= 1'b1;
							end
						end
						CMD_ER_CHIP, CMD_WR_UCFG, CMD_WR_BOOT,
						CMD_WR_SEC: begin
							st_q <= S_WAIT;
							busy <= 1'b1;
						end
						default: err_q <= 1'b1;
					endcase
				end
				S_WAIT: begin
					tmr_q <= tmr_q + 32'h1;
					if (tmr_q == tmr_end) begin
						st_q <= S_IDLE;
						busy <= 1'b0;
						unique case (op_q)
							CMD_PROG_PAGE: pload_q <= '0;
							default: ;
						endcase
					end
				end
				S_CRC: begin
					crc_q  <= crc_step(crc_q, mem[cidx_q]);
					cidx_q <= cidx_q + 13'h1;
					if (cidx_q == cend_q) begin
						st_q <= S_IDLE;
						busy <= 1'b0;
					end
				end
			endcase
		end
	end

	// array contents change only on operation completion
	wire done = ce & (st_q == S_WAIT) & (tmr_q == tmr_end);
	generate
		for (genvar p = 0; p < PAGE_BYTES; p++) begin : g_pbuf
			always_ff @(posedge clock) begin
				if (ce && cmd_go && fpm_cmd_t'(cmd_raw) == CMD_LOAD_BUF
				    && addr_q[5:0] == 6'(p))
					pbuf[p] <= data_q;
			end
		end
	endgenerate

	// loader region at the top is ordinary flash: erasable like any page
	always_ff @(posedge clock) begin
		if (done) begin
			unique case (op_q)
				CMD_ER_BYTE: mem[addr_q] <= ERASED;
				CMD_ER_PAGE:
					for (int i = 0; i < PAGE_BYTES; i++)
						mem[{addr_q[12:6], 6'(i)}] <= ERASED;
				CMD_ER_SECT:
					for (int i = 0; i < SECTOR_BYTES; i++)
						mem[{addr_q[12:10], 10'(i)}] <= ERASED;
				CMD_ER_CHIP:
					for (int i = 0; i < MEM_BYTES; i++)
						mem[i] <= ERASED;
				CMD_PROG_PAGE:
					for (int i = 0; i < PAGE_BYTES; i++)
						if (pload_q[i])
							mem[{addr_q[12:6], 6'(i)}] <= pbuf[i];
				default: ;
			endcase
		end
	end

	// config, boot and security bytes survive rst so a cleared
	// boot status bit really starts the application next time
	always_ff @(posedge clock) begin
		if (done) begin
			unique case (op_q)
				CMD_WR_UCFG: ucfg_nv_q <= data_q;
				CMD_WR_BOOT: begin
					bvec_q  <= data_q;
					bstat_q <= addr_q[0];
				end
				CMD_WR_SEC: sec_q[sect] <= data_q;
				CMD_ER_CHIP:
					for (int s = 0; s < SECTORS; s++)
						sec_q[s] <= SEC_RST;
				default: ;
			endcase
		end
	end

	// power-up capture of config and start address
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			latched_q        <= 1'b0;
			user_config_byte <= UCFG_RST;
			reset_start_addr <= APP_START;
		end else if (ce && !latched_q) begin
			latched_q        <= 1'b1;
			user_config_byte <= ucfg_nv_q;
			reset_start_addr <= (bstat_q | force_isp)
				? {bvec_q, START_LOW}
				: APP_START;
		end
	end

	property p_busy_len;
		@(posedge clock) disable iff (rst)
		$rose(busy) && st_q == S_WAIT |-> busy [*8];
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy dropped early");

	property p_start;
		@(posedge clock) disable iff (rst)
		$rose(latched_q) |-> reset_start_addr ==
			(($past(bstat_q) | $past(force_isp)) ? {$past(bvec_q), START_LOW}
			: APP_START);
	endproperty
	a_start: assert property (p_start)
		else $error("wrong start address");

	property p_ucfg_hold;
		@(posedge clock) disable iff (rst)
		latched_q && $past(latched_q) |-> $stable(user_config_byte);
	endproperty
	a_ucfg_hold: assert property (p_ucfg_hold)
		else $error("config changed after start");

	property p_ack;
		@(posedge clock) disable iff (rst)
		ce && req |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("bus ack timing wrong");

	// byte, page or sector erase or program on a locked sector is refused and flagged
	property p_lock;
		@(posedge clock) disable iff (rst)
		ce && cmd_go && locked && fpm_cmd_t'(cmd_raw) inside
			{CMD_ER_BYTE, CMD_ER_PAGE, CMD_ER_SECT, CMD_PROG_PAGE}
			|=> !busy && err_q && prot_q;
	endproperty
	a_lock: assert property (p_lock)
		else $error("locked sector not refused");

	// an accepted erase or program raises busy and starts the timer
	property p_op_start;
		@(posedge clock) disable iff (rst)
		ce && cmd_go && !locked && fpm_cmd_t'(cmd_raw) inside
			{CMD_ER_BYTE, CMD_ER_PAGE, CMD_ER_SECT, CMD_PROG_PAGE}
			|=> busy && st_q == S_WAIT && tmr_q == 32'h0;
	endproperty
	a_op_start: assert property (p_op_start)
		else $error("operation did not start");

	property p_done;
		@(posedge clock) disable iff (rst)
		done |=> !busy && st_q == S_IDLE;
	endproperty
	a_done: assert property (p_done)
		else $error("busy held past operation time");

	// address and data writes while busy are ignored
	property p_stall;
		@(posedge clock) disable iff (rst)
		ce && wr && st_q != S_IDLE
			|=> $stable(addr_q) && $stable(data_q);
	endproperty
	a_stall: assert property (p_stall)
		else $error("write accepted while busy");

	property p_crc_start;
		@(posedge clock) disable iff (rst)
		ce && cmd_go && fpm_cmd_t'(cmd_raw) == CMD_CRC_ALL
			|=> busy && crc_q == CRC_INIT && cidx_q == 13'h0
			&& cend_q == 13'h1fff;
	endproperty
	a_crc_start: assert property (p_crc_start)
		else $error("crc over whole array set up wrong");

	property p_crc_end;
		@(posedge clock) disable iff (rst)
		ce && st_q == S_CRC && cidx_q == cend_q
			|=> !busy && st_q == S_IDLE;
	endproperty
	a_crc_end: assert property (p_crc_end)
		else $error("crc did not stop at last byte");

	// a buffer load marks and fills exactly the addressed slot
	property p_load;
		@(posedge clock) disable iff (rst)
		ce && cmd_go && fpm_cmd_t'(cmd_raw) == CMD_LOAD_BUF
			|=> pload_q[addr_q[5:0]] && pbuf[addr_q[5:0]] == data_q;
	endproperty
	a_load: assert property (p_load)
		else $error("page buffer load lost");

	property p_prog_clr;
		@(posedge clock) disable iff (rst)
		done && op_q == CMD_PROG_PAGE |=> pload_q == '0;
	endproperty
	a_prog_clr: assert property (p_prog_clr)
		else $error("page buffer marks not cleared");
endmodule
`default_nettype wire

// ### include/fpm_pkg.sv
// fpm_pkg: constants, register map and types for the flash program sequencer
// assumes a 10 MHz core clock and a classic wishbone register bus
//
// Functional notes
// - flash is read, erased and written one byte at a time.
// - memory is four or eight 1 kB sectors of 64-byte pages.
// - sector erase clears 1 kB, page erase clears 64 bytes, any address.
// - chip erase clears all user program memory in one operation.
// - a 64-byte page buffer programs 1 to 64 bytes at once.
// - timing is generated on chip; every operation finishes within 2 ms.
// - no direct verify; a 32-bit crc covers one sector or whole array.
// - functions are requested through the one boot rom entry at ff00h.
// - after reset a zero boot status bit starts execution at 0000h.
// - a set boot status bit starts at boot vector high, 00h low.
// - boot vector leaves factory at 1eh (8 kB) or 0eh (4 kB).
// - factory loader lives in the top 512 bytes and may be erased.
// - forced serial programming entry acts as a set boot status bit.
// - config byte, boot status bit and boot vector are reprogrammable.
// - config byte is latched at power-up; later writes have no effect.
// - one security byte per sector governs that sector's protection.
`default_nettype none
package fpm_pkg;
	localparam int          CLK_HZ        = 10_000_000;
	localparam int          OP_TIME_US    = 2000;
	localparam int          OP_CYCLES     = OP_TIME_US * (CLK_HZ / 1_000_000);
	localparam int          SECTORS       = 8;
	localparam int          SECTOR_BYTES  = 1024;
	localparam int          PAGE_BYTES    = 64;
	localparam int          MEM_BYTES     = SECTORS * SECTOR_BYTES;
	localparam int          LOADER_BYTES  = 512;
	localparam logic [15:0] ENTRY_ADDR    = 16'hff00;
	localparam logic [15:0] APP_START     = 16'h0000;
	localparam logic [7:0]  START_LOW     = 8'h00;
	localparam logic [7:0]  BVEC_RST_8K   = 8'h1e;
	localparam logic [7:0]  BVEC_RST_4K   = 8'h0e;
	localparam logic [7:0]  ERASED        = 8'hff;
	localparam logic [31:0] CRC_POLY      = 32'h04c11db7;
	localparam logic [31:0] CRC_INIT      = 32'hffffffff;
	// register word offsets (byte addresses)
	localparam logic [7:0]  R_ADDR        = 8'h00;
	localparam logic [7:0]  R_DATA        = 8'h04;
	localparam logic [7:0]  R_CMD         = 8'h08;
	localparam logic [7:0]  R_STAT        = 8'h0c;
	localparam logic [7:0]  R_CRC         = 8'h10;
	localparam logic [7:0]  R_BOOT        = 8'h14;
	localparam logic [7:0]  R_UCFG        = 8'h18;
	localparam logic [7:0]  R_SEC         = 8'h1c;
	localparam logic [7:0]  R_PBUF        = 8'h20;
	localparam logic [7:0]  R_START       = 8'h24;
	localparam logic [7:0]  UCFG_RST      = 8'hff;
	localparam logic [7:0]  SEC_RST       = 8'h00;
	typedef enum logic [3:0] {
		CMD_NONE, CMD_RD_BYTE, CMD_ER_BYTE, CMD_ER_PAGE, CMD_ER_SECT,
		CMD_ER_CHIP, CMD_PROG_PAGE, CMD_CRC_SECT, CMD_CRC_ALL,
		CMD_WR_UCFG, CMD_WR_BOOT, CMD_WR_SEC, CMD_LOAD_BUF
	} fpm_cmd_t;
	typedef struct packed {
		logic        busy;
		logic        err;
		logic        protected_hit;
	} fpm_status_t;
endpackage
`default_nettype wire

// ### test/fpm_isp_strap.sv
// fpm_isp_strap: power-on serial programming strap and run enable
// assumes the strap request is sampled while reset is asserted
`default_nettype none
module fpm_isp_strap (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// strap request and outputs
	input  wire logic strap_req,
	output logic      force_isp,
	output logic      ce
);
	timeunit 1ns;
	timeprecision 1ns;
	assign ce = 1'b1;
	// strap is frozen at reset, like a pin held through power-on
	always_ff @(posedge clock) begin
		if (rst)
			force_isp <= strap_req;
	end
endmodule
`default_nettype wire

// ### test/fpm_flash_ctrl_tb.sv
// fpm_flash_ctrl_tb: self-checking bench for the flash sequencer
// assumes the strap model drives force_isp and ce
`default_nettype none
module fpm_flash_ctrl_tb;
	import fpm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int OPC = 12;
	logic        clock = 0, rst = 1, cyc = 0, stb = 0, we = 0, strap = 0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic        ack, busy, fisp, ce;
	logic [15:0] start;
	logic [7:0]  ucfg, b0, b1;
	logic [31:0] exp_q[$], msk_q[$];
	int          bad_count = 0, comparisons = 0, seed = 12;
	fpm_isp_strap strap_m (.clock(clock), .rst(rst), .strap_req(strap),
		.force_isp(fisp), .ce(ce));
	fpm_flash_ctrl #(.OP_CYC(OPC)) dut (.clock(clock), .rst(rst), .ce(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
		.force_isp(fisp), .reset_start_addr(start),
		.user_config_byte(ucfg), .busy(busy));
	always #50 clock = ~clock;
	task automatic chk(input logic [31:0] g, e, m);
		comparisons++;
		if ((g & m) !== (e & m)) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g & m, e & m);
		end
	endtask
	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// read data is compared against the oldest queued note
	always @(posedge clock) begin
		if (ack === 1'b1 && !we && exp_q.size() > 0)
			chk(rdat, exp_q.pop_front(), msk_q.pop_front());
	end
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] e = 0, m = 0);
		@(posedge clock);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		if (!w) begin
			exp_q.push_back(e);
			msk_q.push_back(m);
		end
		do
			@(posedge clock);
		while (ack !== 1'b1);
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic op(input logic [3:0] c, input logic [31:0] a, d,
		input int lim = OPC + 2);
		int n;
		n = 0;
		wb(1, R_ADDR, a);
		wb(1, R_DATA, d);
		wb(1, R_CMD, {28'h0, c});
		while (busy !== 1'b0 && n < 10000) begin
			@(negedge clock);
			n++;
		end
		chk(n <= lim, 1, 1);
	endtask
	function automatic logic [31:0] crc_ff(input int n);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 0; i < n * 8; i++)
			c = c[31] ? {c[30:0], 1'b0} : ({c[30:0], 1'b0} ^ CRC_POLY);
		return c;
	endfunction
	initial begin
		#5_000_000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(posedge clock);
		rst <= 0;
		@(negedge clock);
		@(negedge clock);
		chk(start, 32'h1e00, 32'hffff);
		chk(ucfg, UCFG_RST, 32'hff);
		wb(0, R_BOOT, 0, 32'h11e, 32'h1ff);
		b0 = 8'($random(seed));
		b1 = 8'($random(seed));
		op(12, 32'h0c0, b0);
		op(12, 32'h0ff, b1);
		op(6, 32'h0c0, 0);
		op(1, 32'h0c0, 0);
		wb(0, R_DATA, 0, b0, 32'hff);
		op(2, 32'h0c0, 0);
		op(1, 32'h0c0, 0);
		wb(0, R_DATA, 0, ERASED, 32'hff);
		op(1, 32'h0ff, 0);
		wb(0, R_DATA, 0, b1, 32'hff);
		wb(1, R_CMD, 32'h2);
		wb(1, R_ADDR, 32'h155);
		wb(0, R_ADDR, 0, 32'h0ff, 32'h1fff);
		wait (busy === 1'b0);
		op(3, 32'h0c0, 0);
		op(1, 32'h0ff, 0);
		wb(0, R_DATA, 0, ERASED, 32'hff);
		op(4, 32'h400, 0);
		op(7, 32'h400, 0, 1100);
		wb(0, R_CRC, 0, crc_ff(SECTOR_BYTES), '1);
		op(5, 0, 0);
		op(8, 0, 0, 8300);
		wb(0, R_CRC, 0, crc_ff(MEM_BYTES), '1);
		op(9, 0, 32'h5a);
		wb(0, R_UCFG, 0, 32'h5aff, 32'hffff);
		chk(ucfg, UCFG_RST, 32'hff);
		op(10, 0, 32'h12);
		wb(0, R_BOOT, 0, 32'h012, 32'h1ff);
		op(11, 32'h800, 1);
		wb(0, R_SEC, 0, 1, 1);
		op(4, 32'h800, 0);
		wb(0, R_STAT, 0, 3, 3);
		wb(0, 8'h30, 0, 0, '1);
		rst <= 1;
		repeat (5) @(posedge clock);
		rst <= 0;
		@(negedge clock);
		@(negedge clock);
		chk(start, APP_START, 32'hffff);
		chk(ucfg, 32'h5a, 32'hff);
		wb(0, R_BOOT, 0, 32'h012, 32'h1ff);
		strap <= 1;
		rst <= 1;
		repeat (5) @(posedge clock);
		rst <= 0;
		@(negedge clock);
		@(negedge clock);
		chk(start, 32'h1200, 32'hffff);
		chk(ucfg, 32'h5a, 32'hff);
		repeat (3) @(posedge clock);
		tally_and_finish();
	end
endmodule
`default_nettype wire
